// File: acs_clk_div.sv
`timescale 1ns/1ps
// Divides the selected source into a one-cycle conversion tick.
module acs_clk_div
  import acs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic src_tick,
  input wire logic [2:0] ratio_m1,
  output logic tick
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic wrap;

  // Any ratio from one to eight, odd or even, is a plain modulo count.
  assign wrap = src_tick && (cnt_r >= ratio_m1);
  assign cnt_nxt = !src_tick ? cnt_r : (wrap ? 3'h0 : cnt_r + 3'h1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= DIV_RST;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= wrap;
    end
  end

  div_tick_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tick |-> $past(src_tick))
    else $error("Divider ticked without a source tick.");

endmodule : acs_clk_div

// File: acs_pkg.sv
package acs_pkg;

  // Sequence modes.
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_SEQUENCE = 2'h1;
  localparam logic [1:0] SEQ_REPEAT_SINGLE = 2'h2;
  localparam logic [1:0] SEQ_REPEAT_SEQ = 2'h3;

  // Conversion clock sources.
  localparam logic [1:0] CLK_SEL_SUBMAIN = 2'h3;

  // Channel and timing figures.
  localparam int CHAN_W = 4;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam int SAMPLE_CLKS = 4;
  localparam int CONV_CLKS = 13;
  localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CLKS - 1);
  localparam logic [4:0] CONV_LAST = 5'(SAMPLE_CLKS + CONV_CLKS - 1);
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [4:0] PHASE_RST = 5'h00;
  localparam logic [1:0] SEL_RST = 2'h0;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_ARMED,
    ACS_RUN
  } acs_state_e;

endpackage : acs_pkg

// File: acs_sequencer.sv
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ctl0_wr,
  input wire logic converter_power_bit,
  input wire logic conversion_arm_bit,
  input wire logic software_start_bit,
  input wire logic [1:0] sequence_select_field,
  input wire logic sample_pulse_mode,
  input wire logic timer_trigger,
  input wire logic [3:0] seq_end_chan,
  input wire logic [1:0] conv_clock_select,
  input wire logic [2:0] conv_clock_divider,
  input wire logic [3:0] src_ticks,
  input wire logic submain_gate_off,
  input wire logic overrun_clear,
  output logic conversion_active,
  output logic trigger_overrun_flag,
  output logic [3:0] chan_out,
  output logic sample_hold,
  output logic conv_done
);

  //////////////////////////////////////////////////////////////////////////
  logic src_tick;
  logic tick;
  logic arm_r;
  logic arm_rise;
  logic sw_trig;
  logic tmr_trig;
  logic trig;
  logic seq_mode;
  logic rep_mode;
  logic last_chan;
  logic step_end;
  acs_state_e state_r;
  acs_state_e state_nxt;
  logic [4:0] phase_r;
  logic [3:0] chan_r;

  // A gated sub-main source simply stops ticking and a run waits on it; any
  // new selection drives src_tick in the same cycle, so a switch ends the wait.
  assign src_tick = (conv_clock_select == CLK_SEL_SUBMAIN) ?
    (src_ticks[3] && !submain_gate_off) :
    src_ticks[conv_clock_select];

  acs_clk_div u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .src_tick(src_tick),
    .ratio_m1(conv_clock_divider),
    .tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Triggers. Timer sourcing applies in every mode, single included.
  assign arm_rise = conversion_arm_bit && !arm_r;
  assign sw_trig = software_start_bit && !sample_pulse_mode;
  assign tmr_trig = timer_trigger && sample_pulse_mode;
  // In single mode a bare control-word write is never a trigger; only the
  // software or timer trigger while powered and armed counts.
  assign trig = converter_power_bit && conversion_arm_bit &&
    (sw_trig || tmr_trig);

  assign seq_mode = sequence_select_field[0];
  assign rep_mode = sequence_select_field[1];
  assign last_chan = !seq_mode || (chan_r >= seq_end_chan);
  assign step_end = tick && (phase_r == CONV_LAST);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ACS_IDLE: begin
        if (converter_power_bit && arm_rise) begin
          state_nxt = ACS_ARMED;
        end
      end
      ACS_ARMED: begin
        if (!conversion_arm_bit || !converter_power_bit) begin
          state_nxt = ACS_IDLE;
        end else if (trig) begin
          state_nxt = ACS_RUN;
        end
      end
      ACS_RUN: begin
        if (!converter_power_bit) begin
          state_nxt = ACS_IDLE;
        end else if (step_end && last_chan && !rep_mode) begin
          state_nxt = conversion_arm_bit ? ACS_ARMED : ACS_IDLE;
        end else if (step_end && last_chan && !conversion_arm_bit) begin
          state_nxt = ACS_IDLE;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ACS_IDLE;
      arm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      arm_r <= conversion_arm_bit;
    end
  end

  // Phase and channel advance only on conversion ticks; triggers during a
  // run never touch them.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_r != ACS_RUN) begin
      phase_r <= PHASE_RST;
      chan_r <= CHAN_RST;
    end else if (step_end) begin
      phase_r <= PHASE_RST;
      chan_r <= last_chan ? CHAN_RST : chan_r + 4'h1;
    end else if (tick) begin
      phase_r <= phase_r + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conversion_active <= 1'b0;
      trigger_overrun_flag <= 1'b0;
      chan_out <= CHAN_RST;
      sample_hold <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conversion_active <= (state_nxt == ACS_RUN);
      if ((state_r == ACS_RUN) && (sw_trig || tmr_trig)) begin
        trigger_overrun_flag <= 1'b1;
      end else if (overrun_clear) begin
        trigger_overrun_flag <= 1'b0;
      end
      chan_out <= chan_r;
      sample_hold <= (state_r == ACS_RUN) && (phase_r <= SAMPLE_LAST);
      conv_done <= (state_r == ACS_RUN) && step_end;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  busy_mirror_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    conversion_active == (state_r == ACS_RUN))
    else $error("Active bit does not follow the run state.");

  overrun_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_RUN && (sw_trig || tmr_trig))
    |=> trigger_overrun_flag)
    else $error("Overrun flag missed a trigger during a run.");

  overrun_win_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_RUN && sw_trig && overrun_clear)
    |=> trigger_overrun_flag)
    else $error("Clear beat a simultaneous overrun.");

  write_only_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_ARMED && ctl0_wr && !trig)
    |=> state_r != ACS_RUN)
    else $error("A plain control write started sampling.");

  no_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_RUN && trig && tick && phase_r != CONV_LAST)
    |=> phase_r == $past(phase_r) + 5'h01)
    else $error("Trigger disturbed a running conversion.");

  start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_ARMED && trig && converter_power_bit)
    |=> state_r == ACS_RUN ##1 conversion_active)
    else $error("Armed trigger did not start a conversion.");

  restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_IDLE && converter_power_bit && arm_rise)
    |=> state_r == ACS_ARMED)
    else $error("Power and arm did not restore readiness.");

  submain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (conv_clock_select != CLK_SEL_SUBMAIN)
    |-> src_tick == src_ticks[conv_clock_select])
    else $error("Non sub-main source is blocked.");

  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trigger_overrun_flag && !overrun_clear)
    |=> trigger_overrun_flag)
    else $error("Overrun flag dropped without a clear.");

  run_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_RUN && trig && !step_end)
    |=> state_r == ACS_RUN)
    else $error("Trigger during a run changed the sequence.");

  single_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == ACS_RUN && step_end && !seq_mode && !rep_mode)
    |=> state_r != ACS_RUN)
    else $error("Single mode ran past one conversion.");

  repeat_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == ACS_RUN && rep_mode && step_end && last_chan);
  overrun_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(trigger_overrun_flag));
  seq_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    seq_mode && conv_done && chan_r != CHAN_RST);
  switch_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    submain_gate_off && conv_clock_select != CLK_SEL_SUBMAIN && conv_done);

endmodule : acs_sequencer

// File: acs_timer_model.sv
`timescale 1ns/1ps
module acs_timer_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic run_en,
  input wire logic [7:0] period,
  output logic timer_trigger
);
  logic [7:0] cnt_r;
  // Fires a one-cycle trigger once every period cycles while enabled.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run_en) begin
      cnt_r <= 8'h00;
      timer_trigger <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
      timer_trigger <= (cnt_r == period - 8'h01);
    end
  end
endmodule : acs_timer_model

// File: adc_conversion_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module adc_conversion_sequencer_test
  import acs_pkg::*;
;
  logic ref_clk, sys_rst, ctl0_wr, converter_power_bit, conversion_arm_bit;
  logic software_start_bit, sample_pulse_mode, timer_trigger, tmr_en;
  logic submain_gate_off, overrun_clear, conversion_active, conv_done;
  logic trigger_overrun_flag, sample_hold;
  logic [1:0] sequence_select_field, conv_clock_select;
  logic [2:0] conv_clock_divider;
  logic [3:0] seq_end_chan, src_ticks, chan_out;
  int err_total, comparisons, c;

  acs_sequencer i_dut (.ref_clk, .sys_rst, .ctl0_wr, .converter_power_bit,
    .conversion_arm_bit, .software_start_bit, .sequence_select_field,
    .sample_pulse_mode, .timer_trigger, .seq_end_chan, .conv_clock_select,
    .conv_clock_divider, .src_ticks, .submain_gate_off, .overrun_clear,
    .conversion_active, .trigger_overrun_flag, .chan_out, .sample_hold,
    .conv_done);
  acs_timer_model i_tmr (.ref_clk, .sys_rst, .run_en(tmr_en),
    .period(8'h28), .timer_trigger);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : step
  task automatic start;
    software_start_bit = 1'b1;
    step(1);
    software_start_bit = 1'b0;
  endtask : start
  task automatic wait_done;
    c = 0;
    do begin
      step(1);
      c++;
    end while (conv_done !== 1'b1 && c < 2000);
    `CHK("conv_done", 1'b1, conv_done)
  endtask : wait_done
  task automatic set_mode(input logic [1:0] m, input logic p);
    conversion_arm_bit = 1'b0;
    step(1);
    sequence_select_field = m;
    sample_pulse_mode = p;
    ctl0_wr = 1'b1;
    step(1);
    ctl0_wr = 1'b0;
    conversion_arm_bit = 1'b1;
    step(1);
  endtask : set_mode
  task automatic wrap_up;
    $display("Mismatches %0d of %0d checks", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////////
  task automatic t_manual;
    start;
    step(2);
    `CHK("active", 1'b1, conversion_active)
    `CHK("hold", 1'b1, sample_hold)
    wait_done;
    step(2);
    `CHK("idle", 1'b0, conversion_active)
    start;
    step(4);
    start;
    step(2);
    `CHK("ovr set", 1'b1, trigger_overrun_flag)
    `CHK("hold end", 1'b0, sample_hold)
    wait_done;
    step(30);
    `CHK("no rerun", 1'b0, conversion_active)
    overrun_clear = 1'b1;
    step(1);
    overrun_clear = 1'b0;
    step(1);
    `CHK("ovr clr", 1'b0, trigger_overrun_flag)
    start;
    step(3);
    overrun_clear = 1'b1;
    start;
    overrun_clear = 1'b0;
    step(1);
    `CHK("ovr win", 1'b1, trigger_overrun_flag)
    wait_done;
  endtask : t_manual
  task automatic t_modes;
    set_mode(SEQ_SEQUENCE, 1'b0);
    start;
    step(4);
    start;
    wait_done;
    step(1);
    `CHK("chan next", 4'h1, chan_out)
    repeat (2) wait_done;
    `CHK("chan last", 4'h2, chan_out)
    step(2);
    `CHK("seq end", 1'b0, conversion_active)
    for (int m = 2; m < 4; m++) begin
      set_mode(2'(m), 1'b0);
      start;
      step(4);
      start;
      repeat (2) wait_done;
      conversion_arm_bit = 1'b0;
      wait_done;
      step(2);
      `CHK("rep stop", 1'b0, conversion_active)
    end
  endtask : t_modes
  task automatic t_timer;
    set_mode(SEQ_SINGLE, 1'b1);
    tmr_en = 1'b1;
    repeat (2) wait_done;
    tmr_en = 1'b0;
    step(40);
    ctl0_wr = 1'b1;
    step(1);
    ctl0_wr = 1'b0;
    step(30);
    `CHK("wr no start", 1'b0, conversion_active)
    set_mode(SEQ_SINGLE, 1'b0);
    conversion_arm_bit = 1'b0;
    step(1);
    converter_power_bit = 1'b0;
    step(2);
    converter_power_bit = 1'b1;
    step(1);
    conversion_arm_bit = 1'b1;
    step(1);
    start;
    wait_done;
  endtask : t_timer
  task automatic t_clock;
    for (int d = 0; d < 8; d++) begin
      conv_clock_divider = 3'(d);
      start;
      wait_done;
      `CHK("div", 1'b1, c >= 16 * (d + 1) && c <= 18 * (d + 1) + 4)
    end
    conv_clock_divider = 3'h2;
    for (int s = 1; s < 4; s++) begin
      conv_clock_select = 2'(s);
      src_ticks = 4'(1 << s);
      start;
      wait_done;
    end
    submain_gate_off = 1'b1;
    start;
    step(60);
    `CHK("gated", 1'b1, conversion_active)
    conv_clock_select = 2'h0;
    src_ticks = 4'hF;
    wait_done;
  endtask : t_clock
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {ctl0_wr, converter_power_bit, conversion_arm_bit, tmr_en} = 4'h0;
    {software_start_bit, sample_pulse_mode, overrun_clear} = 3'h0;
    {submain_gate_off, conv_clock_select, conv_clock_divider} = 6'h00;
    sequence_select_field = SEQ_SINGLE;
    seq_end_chan = 4'h2;
    src_ticks = 4'hF;
    err_total = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    step(8);
    sys_rst = 1'b0;
    step(1);
    `CHK("rst active", 1'b0, conversion_active)
    `CHK("rst ovr", 1'b0, trigger_overrun_flag)
    converter_power_bit = 1'b1;
    step(1);
    conversion_arm_bit = 1'b1;
    step(1);
    t_manual;
    t_modes;
    t_timer;
    t_clock;
    wrap_up;
  end
  initial begin
    #(25 * 20000);
    err_total++;
    wrap_up;
  end
endmodule : adc_conversion_sequencer_test
